// ==== rtl/cmp_reg_pkg.sv ====
package cmp_reg_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CMP1_MODE   = 8'h9C;
    localparam logic [7:0] IDX_CMP1_MUX    = 8'h9E;
    localparam logic [7:0] IDX_CMP0_MUX    = 8'h9F;
    localparam logic [7:0] IDX_REG_CTRL    = 8'hC9;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'hA1;
    localparam logic [7:0] IDX_WAKE_CTRL   = 8'hA2;
    localparam int         ADDR_LSB        = 2;
    localparam int         ADDR_W          = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CMP1_MODE   = 8'h02;
    localparam logic [7:0] RST_MUX         = 8'h00;
    localparam logic [7:0] RST_REG_CTRL    = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int         MODE_RISE_EN    = 5;
    localparam int         MODE_FALL_EN    = 4;
    localparam int         MODE_RESP_HI    = 1;
    localparam int         MODE_RESP_LO    = 0;
    localparam logic [7:0] MODE_WR_MASK    = 8'h33;
    localparam int         MUX_NEG_HI      = 6;
    localparam int         MUX_NEG_LO      = 4;
    localparam int         MUX_POS_HI      = 2;
    localparam int         MUX_POS_LO      = 0;
    localparam logic [7:0] MUX_WR_MASK     = 8'h77;
    localparam int         REG_MAIN_DIS    = 7;
    localparam int         REG_WAKE_LVL    = 6;
    localparam int         REG_MAIN_LP     = 4;
    localparam int         REG_STOP_SHDN   = 3;
    localparam int         REG_CORE_LP     = 1;
    localparam int         IRQ_RISE        = 0;
    localparam int         IRQ_FALL        = 1;
    localparam int         IRQ_W           = 2;
    localparam int         WAKE_EN         = 0;

    typedef struct packed {
        logic [2:0] neg_select;
        logic [2:0] pos_select;
    } mux_sel_s;

    typedef struct packed {
        logic       main_regulator_disable;
        logic       main_regulator_low_power;
        logic       core_regulator_low_power;
        logic       stop_regulator_shutdown;
        logic       core_regulator_off;
    } reg_ctl_s;

endpackage

// ==== rtl/comparator_mux_regulator_ctrl.sv ====
// Summary of operation
// [RQ1] mode bit 5 enables rising-edge interrupt
// [RQ2] mode bit 4 enables falling-edge interrupt
// [RQ3] mode bits 7:6, 3:2 read zero
// [RQ4] mode bits 1:0 select response speed
// [RQ5] positive selector picks comparator plus pin
// [RQ6] bits 6:4 pick comparator minus pin
// [RQ7] positive selector bits 2:0, codes 5-7 reserved
// [RQ8] mux bits 7 and 3 read zero
// [RQ9] bit 7 disables main regulator
// [RQ10] bit 4 selects main regulator low power
// [RQ11] bit 6 reads wake pin level
// [RQ12] wake pin interrupts on both edges
// [RQ13] wake interrupt has no pending flag
// [RQ14] shutdown bit clear keeps core regulator in stop
// [RQ15] shutdown bit set powers core off in stop
// [RQ16] core low power only for suspend
// [RQ17] twelve instructions before oscillator suspend
// [RQ18] wake pin synchronised before edge detection
`timescale 1ns/1ns
module comparator_mux_regulator_ctrl #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // apb slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [11:0]            paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // analog side
    input  wire logic                   cmp1_level_in,
    input  wire logic                   wake_edge_pin_in,
    input  wire logic                   stop_mode_in,
    output logic      [1:0]             cmp1_response_mode_out,
    output cmp_reg_pkg::mux_sel_s       cmp0_select_out,
    output cmp_reg_pkg::mux_sel_s       cmp1_select_out,
    output cmp_reg_pkg::reg_ctl_s       regulator_out,
    // interrupts
    output logic                        cmp_irq_out,
    output logic                        wake_irq_out
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_async;
    logic [1:0] sync_q [SYNC_STAGES];
    logic [1:0] pin_sync;
    logic [1:0] pin_prev_r;

    assign pin_async = {wake_edge_pin_in, cmp1_level_in};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_STAGES; gi++) begin : g_sync
            if (gi == 0) begin : g_first
                always_ff @(posedge clk_sys_in or posedge rst_in) begin
                    if (rst_in) begin
                        sync_q[gi] <= 2'h0;
                    end else begin
                        sync_q[gi] <= pin_async;
                    end
                end
            end else begin : g_next
                always_ff @(posedge clk_sys_in or posedge rst_in) begin
                    if (rst_in) begin
                        sync_q[gi] <= 2'h0;
                    end else begin
                        sync_q[gi] <= sync_q[gi-1];
                    end
                end
            end
        end
    endgenerate

    assign pin_sync = sync_q[SYNC_STAGES-1]; // RQ18

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_prev_r <= 2'h0;
        end else begin
            pin_prev_r <= pin_sync;
        end
    end

    logic cmp_rise;
    logic cmp_fall;
    logic wake_edge;
    logic prev_valid_r;

    // first cycle after reset has no valid history, so no edge is reported
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prev_valid_r <= 1'b0;
        end else begin
            prev_valid_r <= 1'b1;
        end
    end

    assign cmp_rise  = prev_valid_r & pin_sync[0] & ~pin_prev_r[0];
    assign cmp_fall  = prev_valid_r & ~pin_sync[0] & pin_prev_r[0];
    assign wake_edge = prev_valid_r & (pin_sync[1] ^ pin_prev_r[1]); // RQ12

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic       setup_ph;
    logic       access_ph;
    logic       wr_en;
    logic [9:0] reg_idx;
    logic       hit_mode;
    logic       hit_mux1;
    logic       hit_mux0;
    logic       hit_reg;
    logic       hit_stat;
    logic       hit_mask;
    logic       hit_wake;
    logic       mapped;
    logic [7:0] wdata;

    assign setup_ph  = psel_in & ~penable_in;
    assign access_ph = psel_in & penable_in;
    assign wr_en     = access_ph & pwrite_in;
    assign reg_idx   = paddr_in[cmp_reg_pkg::ADDR_W-1:cmp_reg_pkg::ADDR_LSB];
    assign wdata     = pwdata_in[7:0];
    assign hit_mode  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_CMP1_MODE});
    assign hit_mux1  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_CMP1_MUX});
    assign hit_mux0  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_CMP0_MUX});
    assign hit_reg   = (reg_idx == {2'h0, cmp_reg_pkg::IDX_REG_CTRL});
    assign hit_stat  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_IRQ_STATUS});
    assign hit_mask  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_IRQ_MASK});
    assign hit_wake  = (reg_idx == {2'h0, cmp_reg_pkg::IDX_WAKE_CTRL});
    assign mapped    = hit_mode | hit_mux1 | hit_mux0 | hit_reg | hit_stat | hit_mask | hit_wake;
    assign pready_out  = access_ph;
    assign pslverr_out = access_ph & ~mapped;

    // ------------------------------------------------------------
    // comparator1 mode register
    // ------------------------------------------------------------
    logic [7:0] cmp1_mode_r;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmp1_mode_r <= cmp_reg_pkg::RST_CMP1_MODE;
        end else if (wr_en && hit_mode) begin
            cmp1_mode_r <= wdata & cmp_reg_pkg::MODE_WR_MASK; // RQ3
        end
    end

    logic cmp1_rise_irq_en;
    logic cmp1_fall_irq_en;

    assign cmp1_rise_irq_en = cmp1_mode_r[cmp_reg_pkg::MODE_RISE_EN];
    assign cmp1_fall_irq_en = cmp1_mode_r[cmp_reg_pkg::MODE_FALL_EN];
    assign cmp1_response_mode_out =
        cmp1_mode_r[cmp_reg_pkg::MODE_RESP_HI:cmp_reg_pkg::MODE_RESP_LO]; // RQ4

    // ------------------------------------------------------------
    // comparator input multiplexer registers
    // ------------------------------------------------------------
    logic [7:0] cmp0_mux_r;
    logic [7:0] cmp1_mux_r;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmp0_mux_r <= cmp_reg_pkg::RST_MUX;
        end else if (wr_en && hit_mux0) begin
            cmp0_mux_r <= wdata & cmp_reg_pkg::MUX_WR_MASK; // RQ8
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmp1_mux_r <= cmp_reg_pkg::RST_MUX;
        end else if (wr_en && hit_mux1) begin
            cmp1_mux_r <= wdata & cmp_reg_pkg::MUX_WR_MASK; // RQ8
        end
    end

    // reserved positive codes are passed through untouched
    assign cmp0_select_out.pos_select = cmp0_mux_r[cmp_reg_pkg::MUX_POS_HI:cmp_reg_pkg::MUX_POS_LO]; // RQ5 RQ7
    assign cmp0_select_out.neg_select = cmp0_mux_r[cmp_reg_pkg::MUX_NEG_HI:cmp_reg_pkg::MUX_NEG_LO]; // RQ6
    assign cmp1_select_out.pos_select = cmp1_mux_r[cmp_reg_pkg::MUX_POS_HI:cmp_reg_pkg::MUX_POS_LO]; // RQ5 RQ7
    assign cmp1_select_out.neg_select = cmp1_mux_r[cmp_reg_pkg::MUX_NEG_HI:cmp_reg_pkg::MUX_NEG_LO]; // RQ6

    // ------------------------------------------------------------
    // regulator control register
    // ------------------------------------------------------------
    logic main_dis_r;
    logic main_lp_r;
    logic stop_shdn_r;
    logic core_lp_r;

    // reserved bits are not stored, so they read back as zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            main_dis_r <= cmp_reg_pkg::RST_REG_CTRL[cmp_reg_pkg::REG_MAIN_DIS];
        end else if (wr_en && hit_reg) begin
            main_dis_r <= wdata[cmp_reg_pkg::REG_MAIN_DIS]; // RQ9
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            main_lp_r <= cmp_reg_pkg::RST_REG_CTRL[cmp_reg_pkg::REG_MAIN_LP];
        end else if (wr_en && hit_reg) begin
            main_lp_r <= wdata[cmp_reg_pkg::REG_MAIN_LP]; // RQ10
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            stop_shdn_r <= cmp_reg_pkg::RST_REG_CTRL[cmp_reg_pkg::REG_STOP_SHDN];
        end else if (wr_en && hit_reg) begin
            stop_shdn_r <= wdata[cmp_reg_pkg::REG_STOP_SHDN];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            core_lp_r <= cmp_reg_pkg::RST_REG_CTRL[cmp_reg_pkg::REG_CORE_LP];
        end else if (wr_en && hit_reg) begin
            core_lp_r <= wdata[cmp_reg_pkg::REG_CORE_LP];
        end
    end

    assign regulator_out.main_regulator_disable   = main_dis_r;  // RQ9
    assign regulator_out.main_regulator_low_power = main_lp_r;   // RQ10
    assign regulator_out.core_regulator_low_power = core_lp_r;
    assign regulator_out.stop_regulator_shutdown  = stop_shdn_r;
    // core stays powered in stop unless shutdown was armed
    assign regulator_out.core_regulator_off       = stop_shdn_r & stop_mode_in; // RQ14 RQ15

    // ------------------------------------------------------------
    // wake pin interrupt, delivered without a pending flag
    // ------------------------------------------------------------
    logic wake_en_r;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wake_en_r <= 1'b0;
        end else if (wr_en && hit_wake) begin
            wake_en_r <= wdata[cmp_reg_pkg::WAKE_EN];
        end
    end

    // one-cycle request with nothing to poll: the consumer must take it as an edge
    assign wake_irq_out = wake_en_r & wake_edge; // RQ12 RQ13

    // ------------------------------------------------------------
    // comparator interrupt status and mask
    // ------------------------------------------------------------
    logic [cmp_reg_pkg::IRQ_W-1:0] irq_stat_r;
    logic [cmp_reg_pkg::IRQ_W-1:0] irq_mask_r;
    logic [cmp_reg_pkg::IRQ_W-1:0] irq_set;
    logic [cmp_reg_pkg::IRQ_W-1:0] irq_clr;
    logic [cmp_reg_pkg::IRQ_W-1:0] stat_seen_r;

    always_comb begin
        irq_set = '0;
        irq_set[cmp_reg_pkg::IRQ_RISE] = cmp_rise & cmp1_rise_irq_en; // RQ1
        irq_set[cmp_reg_pkg::IRQ_FALL] = cmp_fall & cmp1_fall_irq_en; // RQ2
    end

    // only bits already returned to the reader are cleared
    assign irq_clr = (access_ph && !pwrite_in && hit_stat) ? stat_seen_r : '0;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_r <= '0;
        end else if (wr_en && hit_mask) begin
            irq_mask_r <= wdata[cmp_reg_pkg::IRQ_W-1:0];
        end
    end

    assign cmp_irq_out = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // read data, captured in the setup phase
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] reg_ctrl_rd;

    always_comb begin
        reg_ctrl_rd = 8'h00;
        reg_ctrl_rd[cmp_reg_pkg::REG_MAIN_DIS]  = main_dis_r;
        reg_ctrl_rd[cmp_reg_pkg::REG_WAKE_LVL]  = pin_sync[1]; // RQ11
        reg_ctrl_rd[cmp_reg_pkg::REG_MAIN_LP]   = main_lp_r;
        reg_ctrl_rd[cmp_reg_pkg::REG_STOP_SHDN] = stop_shdn_r;
        reg_ctrl_rd[cmp_reg_pkg::REG_CORE_LP]   = core_lp_r;
    end

    always_comb begin
        rd_mux = 8'h00;
        if (hit_mode) begin
            rd_mux = cmp1_mode_r;
        end else if (hit_mux1) begin
            rd_mux = cmp1_mux_r;
        end else if (hit_mux0) begin
            rd_mux = cmp0_mux_r;
        end else if (hit_reg) begin
            rd_mux = reg_ctrl_rd;
        end else if (hit_stat) begin
            rd_mux = {6'h00, irq_stat_r};
        end else if (hit_mask) begin
            rd_mux = {6'h00, irq_mask_r};
        end else if (hit_wake) begin
            rd_mux = {7'h00, wake_en_r};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_ph && !pwrite_in) begin
            prdata_out <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            stat_seen_r <= '0;
        end else if (setup_ph) begin
            stat_seen_r <= irq_stat_r;
        end
    end

endmodule

// ==== testbench/cmr_checker.sv ====
`timescale 1ns/1ns
module cmr_checker #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // apb slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [11:0]            paddr_in,
    input  wire logic [31:0]            pwdata_in,
    input  wire logic [31:0]            prdata_out,
    input  wire logic                   pready_out,
    input  wire logic                   pslverr_out,
    // analog side
    input  wire logic                   cmp1_level_in,
    input  wire logic                   wake_edge_pin_in,
    input  wire logic                   stop_mode_in,
    input  wire logic [1:0]             cmp1_response_mode_out,
    input  wire cmp_reg_pkg::mux_sel_s  cmp0_select_out,
    input  wire cmp_reg_pkg::mux_sel_s  cmp1_select_out,
    input  wire cmp_reg_pkg::reg_ctl_s  regulator_out,
    // interrupts
    input  wire logic                   cmp_irq_out,
    input  wire logic                   wake_irq_out
);
    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic acc_wr;
    logic [9:0] widx;
    assign acc_wr = psel_in && penable_in && pwrite_in;
    assign widx   = paddr_in[11:2];

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_READY_ZERO_WAIT: assert property (pready_out == (psel_in && penable_in))
        else $error("pready does not follow access phase");
    AST_SLVERR_ACCESS: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("slave error outside access phase");
    AST_RDATA_UPPER: assert property (psel_in && penable_in |-> prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RESP_MODE_WR: assert property (acc_wr && widx == {2'b00, cmp_reg_pkg::IDX_CMP1_MODE}
        |=> cmp1_response_mode_out == $past(pwdata_in[1:0]))
        else $error("response mode not written");
    AST_MUX1_WR: assert property (acc_wr && widx == {2'b00, cmp_reg_pkg::IDX_CMP1_MUX}
        |=> cmp1_select_out == {$past(pwdata_in[6:4]), $past(pwdata_in[2:0])})
        else $error("comparator1 selectors not written");
    AST_MUX0_WR: assert property (acc_wr && widx == {2'b00, cmp_reg_pkg::IDX_CMP0_MUX}
        |=> cmp0_select_out == {$past(pwdata_in[6:4]), $past(pwdata_in[2:0])})
        else $error("comparator0 selectors not written");
    AST_REG_WR: assert property (acc_wr && widx == {2'b00, cmp_reg_pkg::IDX_REG_CTRL}
        |=> regulator_out.main_regulator_disable == $past(pwdata_in[7])
        && regulator_out.main_regulator_low_power == $past(pwdata_in[4])
        && regulator_out.stop_regulator_shutdown == $past(pwdata_in[3])
        && regulator_out.core_regulator_low_power == $past(pwdata_in[1]))
        else $error("regulator controls not written");
    AST_CORE_OFF: assert property (regulator_out.core_regulator_off ==
        (regulator_out.stop_regulator_shutdown && stop_mode_in))
        else $error("core regulator off state wrong");
    AST_WAKE_PULSE: assert property (wake_irq_out |=> !wake_irq_out)
        else $error("wake interrupt longer than one cycle");
    AST_WAKE_QUIET: assert property ($stable(wake_edge_pin_in) [*8] |=> !wake_irq_out)
        else $error("wake interrupt without pin edge");
endmodule

bind comparator_mux_regulator_ctrl cmr_checker #(.SYNC_STAGES(SYNC_STAGES)) chk_u (.*);

// ==== testbench/comparator_mux_regulator_ctrl_tb.sv ====
`timescale 1ns/1ns
module comparator_mux_regulator_ctrl_tb;
    localparam logic [11:0] A_MODE = {2'b00, cmp_reg_pkg::IDX_CMP1_MODE, 2'b00};
    localparam logic [11:0] A_MUX1 = {2'b00, cmp_reg_pkg::IDX_CMP1_MUX, 2'b00};
    localparam logic [11:0] A_MUX0 = {2'b00, cmp_reg_pkg::IDX_CMP0_MUX, 2'b00};
    localparam logic [11:0] A_REG  = {2'b00, cmp_reg_pkg::IDX_REG_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, cmp_reg_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, cmp_reg_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_WAKE = {2'b00, cmp_reg_pkg::IDX_WAKE_CTRL, 2'b00};

    logic clk, rst, psel, pen, pwr, pready, pslverr, lvl, pin, stop, cirq, wirq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  resp;
    logic        e;
    cmp_reg_pkg::mux_sel_s sel0, sel1;
    cmp_reg_pkg::reg_ctl_s regs;
    int fail_count, samples_checked, wake_cnt, c0;

    comparator_mux_regulator_ctrl dut_u (
        .clk_sys_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cmp1_level_in(lvl), .wake_edge_pin_in(pin), .stop_mode_in(stop),
        .cmp1_response_mode_out(resp), .cmp0_select_out(sel0), .cmp1_select_out(sel1),
        .regulator_out(regs), .cmp_irq_out(cirq), .wake_irq_out(wirq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (wirq === 1'b1) wake_cnt++;

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        paddr  <= a;
        pwr    <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        // one more edge so that a write has landed before the caller looks
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h000000, d});
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 32'h00000000);
        chk(nm, q, {24'h000000, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        wait_cyc(4000);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h00000000;
        lvl = 1'b0; pin = 1'b0; stop = 1'b0;
        fail_count = 0; samples_checked = 0; wake_cnt = 0;
        wait_cyc(6);
        rst <= 1'b0;
        rd("mode_reset", A_MODE, cmp_reg_pkg::RST_CMP1_MODE);
        rd("mux1_reset", A_MUX1, 8'h00);
        rd("mux0_reset", A_MUX0, 8'h00);
        rd("reg_reset", A_REG, 8'h00);
        wr(A_MODE, 8'hFF);
        rd("mode_unused", A_MODE, 8'h33);
        for (int m = 0; m < 4; m++) begin
            wr(A_MODE, 8'(m));
            chk("resp_mode", {30'h0, resp}, 32'(m));
        end
        wr(A_MUX0, 8'hCC);
        rd("mux0_unused", A_MUX0, 8'h44);
        for (int c = 0; c < 5; c++) begin
            wr(A_MUX1, {1'b1, 3'(4 - c), 1'b1, 3'(c)});
            chk("mux1_sel", {26'h0, sel1}, {26'h0, 3'(4 - c), 3'(c)});
            rd("mux1_read", A_MUX1, {1'b0, 3'(4 - c), 1'b0, 3'(c)});
        end
        chk("mux0_sel", {26'h0, sel0}, 32'h00000024);
        wr(A_REG, 8'h5A);
        wait_cyc(12);
        rd("reg_bits", A_REG, 8'h1A);
        chk("reg_out", {27'h0, regs}, 32'h0000000E);
        stop <= 1'b1;
        wait_cyc(1);
        chk("core_off", {31'h0, regs.core_regulator_off}, 32'h1);
        wr(A_REG, 8'h80);
        chk("core_on", {31'h0, regs.core_regulator_off}, 32'h0);
        rd("reg_dis", A_REG, 8'h80);
        chk("reg_dis_out", {27'h0, regs}, 32'h00000010);
        stop <= 1'b0;
        xfer(12'h3FC, 1'b0, 32'h00000000);
        chk("unmapped_data", q, 32'h00000000);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        wr(A_MASK, 8'h03);
        wr(A_MODE, 8'h20);
        lvl <= 1'b1;
        wait_cyc(6);
        chk("rise_irq", {31'h0, cirq}, 32'h1);
        rd("rise_stat", A_STAT, 8'h01);
        chk("irq_clear", {31'h0, cirq}, 32'h0);
        lvl <= 1'b0;
        wait_cyc(6);
        rd("fall_off", A_STAT, 8'h00);
        wr(A_MODE, 8'h10);
        lvl <= 1'b1;
        wait_cyc(6);
        lvl <= 1'b0;
        wait_cyc(6);
        rd("fall_stat", A_STAT, 8'h02);
        rd("rise_off", A_STAT, 8'h00);
        wr(A_MASK, 8'h00);
        wr(A_MODE, 8'h30);
        lvl <= 1'b1;
        wait_cyc(6);
        chk("masked_irq", {31'h0, cirq}, 32'h0);
        rd("masked_stat", A_STAT, 8'h01);
        wr(A_WAKE, 8'h01);
        c0 = wake_cnt;
        pin <= 1'b1;
        wait_cyc(8);
        chk("wake_rise", 32'(wake_cnt - c0), 32'h1);
        rd("wake_level", A_REG, 8'hC0);
        pin <= 1'b0;
        wait_cyc(8);
        chk("wake_fall", 32'(wake_cnt - c0), 32'h2);
        rd("wake_no_flag", A_STAT, 8'h00);
        rd("wake_low", A_REG, 8'h80);
        wr(A_WAKE, 8'h00);
        pin <= 1'b1;
        wait_cyc(8);
        chk("wake_masked", 32'(wake_cnt - c0), 32'h2);
        summarize();
    end
endmodule
